// [design/pieb_defines.svh]
// offsets, field positions, masks and reset values of the peripheral interrupt bank
`ifndef PIEB_DEFINES_SVH
`define PIEB_DEFINES_SVH

`define PIEB_ADDR_W          8
`define PIEB_OFF_CORE_CTRL   8'h00
`define PIEB_OFF_EN1         8'h04
`define PIEB_OFF_EN2         8'h08
`define PIEB_OFF_EN3         8'h0c
`define PIEB_OFF_FLAGS1      8'h10
`define PIEB_OFF_FLAGS2      8'h14
`define PIEB_OFF_FLAGS3      8'h18
`define PIEB_OFF_EVT_STATUS  8'h1c
`define PIEB_OFF_EVT_MASK    8'h20

`define PIEB_BIT_GLOBAL_EN   7
`define PIEB_BIT_PERIPH_GATE 6

`define PIEB_MASK_CORE_CTRL  8'hc0
`define PIEB_MASK_EN1        8'hff
`define PIEB_MASK_EN2        8'hef
`define PIEB_MASK_EN3        8'h7f
`define PIEB_WMASK_FLAGS1    8'hcf
`define PIEB_LMASK_FLAGS1    8'h30
`define PIEB_MASK_FLAGS2     8'hef
`define PIEB_MASK_FLAGS3     8'h7f
`define PIEB_ZERO_LMASK      8'h00

`define PIEB_RESET_BYTE      8'h00

`define PIEB_EVT_W           2
`define PIEB_EVT_REQ_RISE    0
`define PIEB_EVT_BAD_ACCESS  1
`define PIEB_EVT_RESET       2'h0

`endif

// [design/pieb_pkg.sv]
// types and address decode shared by the peripheral interrupt bank
`include "pieb_defines.svh"
package pieb_pkg;

	typedef enum logic [3:0] {
		PIEB_SEL_NONE       = 4'h0,
		PIEB_SEL_CORE_CTRL  = 4'h1,
		PIEB_SEL_EN1        = 4'h2,
		PIEB_SEL_EN2        = 4'h3,
		PIEB_SEL_EN3        = 4'h4,
		PIEB_SEL_FLAGS1     = 4'h5,
		PIEB_SEL_FLAGS2     = 4'h6,
		PIEB_SEL_FLAGS3     = 4'h7,
		PIEB_SEL_EVT_STATUS = 4'h8,
		PIEB_SEL_EVT_MASK   = 4'h9
	} pieb_sel_t;

	function automatic pieb_sel_t pieb_decode(input logic [`PIEB_ADDR_W-1:0] addr);
		case (addr)
			`PIEB_OFF_CORE_CTRL:  pieb_decode = PIEB_SEL_CORE_CTRL;
			`PIEB_OFF_EN1:        pieb_decode = PIEB_SEL_EN1;
			`PIEB_OFF_EN2:        pieb_decode = PIEB_SEL_EN2;
			`PIEB_OFF_EN3:        pieb_decode = PIEB_SEL_EN3;
			`PIEB_OFF_FLAGS1:     pieb_decode = PIEB_SEL_FLAGS1;
			`PIEB_OFF_FLAGS2:     pieb_decode = PIEB_SEL_FLAGS2;
			`PIEB_OFF_FLAGS3:     pieb_decode = PIEB_SEL_FLAGS3;
			`PIEB_OFF_EVT_STATUS: pieb_decode = PIEB_SEL_EVT_STATUS;
			`PIEB_OFF_EVT_MASK:   pieb_decode = PIEB_SEL_EVT_MASK;
			default:              pieb_decode = PIEB_SEL_NONE;
		endcase
	endfunction : pieb_decode

endpackage : pieb_pkg

// [design/pieb_flag_reg.sv]
// one 8-bit flag register: hardware set wins over software write, level bits follow their source
`timescale 1ns/10ps
`include "pieb_defines.svh"
module pieb_flag_reg
	import pieb_pkg::*;
#(
	parameter logic [7:0] WMASK = 8'hff,
	parameter logic [7:0] LMASK = 8'h00
) (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// software write
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	// hardware sources
	input  wire logic [7:0] set_pulse,
	input  wire logic [7:0] src_level,
	// state
	output logic      [7:0] flags
);

	logic [7:0] flags_reg;
	logic [7:0] flags_next;

	always_comb begin
		flags_next = flags_reg;
		if (wr_en) begin
			flags_next = (flags_reg & ~WMASK) | (wr_data & WMASK);
		end
		flags_next = flags_next | (set_pulse & WMASK);
		flags_next = (flags_next & ~LMASK) | (src_level & LMASK);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= `PIEB_RESET_BYTE;
		end else begin
			flags_reg <= flags_next & (WMASK | LMASK);
		end
	end

	assign flags = flags_reg;

endmodule : pieb_flag_reg

// [design/pieb_evt_irq.sv]
// sticky event status with write-one-to-clear, mask and a registered level interrupt
`timescale 1ns/10ps
`include "pieb_defines.svh"
module pieb_evt_irq
	import pieb_pkg::*;
(
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// events and software access
	input  wire logic [`PIEB_EVT_W-1:0] evt_pulse,
	input  wire logic                  clr_en,
	input  wire logic                  mask_wr_en,
	input  wire logic [`PIEB_EVT_W-1:0] wr_data,
	// state
	output logic      [`PIEB_EVT_W-1:0] status,
	output logic      [`PIEB_EVT_W-1:0] mask,
	output logic                       irq
);

	logic [`PIEB_EVT_W-1:0] status_reg;
	logic [`PIEB_EVT_W-1:0] mask_reg;
	logic                   irq_reg;
	logic [`PIEB_EVT_W-1:0] status_next;

	// a new event in the clearing cycle survives
	assign status_next = (status_reg & ~(clr_en ? wr_data : `PIEB_EVT_RESET)) | evt_pulse;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= `PIEB_EVT_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg <= `PIEB_EVT_RESET;
		end else if (mask_wr_en) begin
			mask_reg <= wr_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_next & (mask_wr_en ? wr_data : mask_reg));
		end
	end

	assign status = status_reg;
	assign mask   = mask_reg;
	assign irq    = irq_reg;

endmodule : pieb_evt_irq

// [design/pieb_top.sv]
// peripheral interrupt enable and flag bank with an APB register port
`timescale 1ns/10ps
`include "pieb_defines.svh"
module pieb_top
	import pieb_pkg::*;
(
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [`PIEB_ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic      [31:0]             prdata,
	output logic                         pslverr,
	// peripheral event pulses, one per flag bit
	input  wire logic [7:0]              flag_set_1,
	input  wire logic [7:0]              flag_set_2,
	input  wire logic [7:0]              flag_set_3,
	// serial receive and transmit condition levels
	input  wire logic                    serial_rx_level,
	input  wire logic                    serial_tx_level,
	// toward the core
	output logic                         periph_irq_req,
	output logic                         global_irq_enable,
	output logic                         irq
);

	//////////////////////////////////////////////////////////////////////////////////////////////
	// bus decode

	pieb_sel_t  sel_setup;
	pieb_sel_t  sel_access;
	logic       setup_phase;
	logic       access_phase;
	logic       write_fire;
	logic       unmapped_setup;
	logic [7:0] wbyte;

	assign setup_phase    = psel & ~penable;
	assign access_phase   = psel & penable;
	assign write_fire     = access_phase & pwrite;
	assign wbyte          = pwdata[7:0];
	assign sel_setup      = pieb_decode(paddr);
	assign sel_access     = write_fire ? pieb_decode(paddr) : PIEB_SEL_NONE;
	assign unmapped_setup = (sel_setup == PIEB_SEL_NONE);

	// one write strobe per register, high only in the access cycle of a write
	logic wr_core_ctrl;
	logic wr_en1;
	logic wr_en2;
	logic wr_en3;
	logic wr_flags1;
	logic wr_flags2;
	logic wr_flags3;
	logic wr_evt_status;
	logic wr_evt_mask;

	assign wr_core_ctrl  = (sel_access == PIEB_SEL_CORE_CTRL);
	assign wr_en1        = (sel_access == PIEB_SEL_EN1);
	assign wr_en2        = (sel_access == PIEB_SEL_EN2);
	assign wr_en3        = (sel_access == PIEB_SEL_EN3);
	assign wr_flags1     = (sel_access == PIEB_SEL_FLAGS1);
	assign wr_flags2     = (sel_access == PIEB_SEL_FLAGS2);
	assign wr_flags3     = (sel_access == PIEB_SEL_FLAGS3);
	assign wr_evt_status = (sel_access == PIEB_SEL_EVT_STATUS);
	assign wr_evt_mask   = (sel_access == PIEB_SEL_EVT_MASK);

	//////////////////////////////////////////////////////////////////////////////////////////////
	// core control and enable registers

	logic [7:0] core_irq_control_reg;
	logic [7:0] periph_irq_enable_1_reg;
	logic [7:0] periph_irq_enable_2_reg;
	logic [7:0] periph_irq_enable_3_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_irq_control_reg <= `PIEB_RESET_BYTE;
		end else if (wr_core_ctrl) begin
			// only the global enable and the peripheral gate are kept
			core_irq_control_reg <= wbyte & `PIEB_MASK_CORE_CTRL;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_irq_enable_1_reg <= `PIEB_RESET_BYTE;
		end else if (wr_en1) begin
			periph_irq_enable_1_reg <= wbyte & `PIEB_MASK_EN1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_irq_enable_2_reg <= `PIEB_RESET_BYTE;
		end else if (wr_en2) begin
			periph_irq_enable_2_reg <= wbyte & `PIEB_MASK_EN2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_irq_enable_3_reg <= `PIEB_RESET_BYTE;
		end else if (wr_en3) begin
			periph_irq_enable_3_reg <= wbyte & `PIEB_MASK_EN3;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////////////
	// flag registers

	logic [7:0] periph_irq_flags_1;
	logic [7:0] periph_irq_flags_2;
	logic [7:0] periph_irq_flags_3;
	logic [7:0] serial_levels;

	// bits 5 and 4 carry the receive and transmit conditions
	assign serial_levels = {2'h0, serial_rx_level, serial_tx_level, 4'h0};

	pieb_flag_reg #(
		.WMASK (`PIEB_WMASK_FLAGS1),
		.LMASK (`PIEB_LMASK_FLAGS1)
	) u_flags_1 (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr_en     (wr_flags1),
		.wr_data   (wbyte),
		.set_pulse (flag_set_1),
		.src_level (serial_levels),
		.flags     (periph_irq_flags_1)
	);

	pieb_flag_reg #(
		.WMASK (`PIEB_MASK_FLAGS2),
		.LMASK (`PIEB_ZERO_LMASK)
	) u_flags_2 (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr_en     (wr_flags2),
		.wr_data   (wbyte),
		.set_pulse (flag_set_2),
		.src_level (`PIEB_RESET_BYTE),
		.flags     (periph_irq_flags_2)
	);

	pieb_flag_reg #(
		.WMASK (`PIEB_MASK_FLAGS3),
		.LMASK (`PIEB_ZERO_LMASK)
	) u_flags_3 (
		.pclk      (pclk),
		.presetn   (presetn),
		.wr_en     (wr_flags3),
		.wr_data   (wbyte),
		.set_pulse (flag_set_3),
		.src_level (`PIEB_RESET_BYTE),
		.flags     (periph_irq_flags_3)
	);

	//////////////////////////////////////////////////////////////////////////////////////////////
	// request toward the core

	logic req_raw;
	logic hit_1;
	logic hit_2;
	logic hit_3;
	logic periph_irq_req_reg;
	logic global_irq_enable_reg;

	// a register pair asks for service when any flag meets its enable
	function automatic logic pieb_pair_hit(input logic [7:0] flags, input logic [7:0] enables);
		pieb_pair_hit = |(flags & enables);
	endfunction : pieb_pair_hit

	assign hit_1   = pieb_pair_hit(periph_irq_flags_1, periph_irq_enable_1_reg);
	assign hit_2   = pieb_pair_hit(periph_irq_flags_2, periph_irq_enable_2_reg);
	assign hit_3   = pieb_pair_hit(periph_irq_flags_3, periph_irq_enable_3_reg);
	assign req_raw = core_irq_control_reg[`PIEB_BIT_PERIPH_GATE] & (hit_1 | hit_2 | hit_3);

	// both outputs toward the core are registered so they leave straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_irq_req_reg <= 1'b0;
		end else begin
			periph_irq_req_reg <= req_raw;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_irq_enable_reg <= 1'b0;
		end else begin
			global_irq_enable_reg <= core_irq_control_reg[`PIEB_BIT_GLOBAL_EN];
		end
	end

	assign periph_irq_req    = periph_irq_req_reg;
	assign global_irq_enable = global_irq_enable_reg;

	//////////////////////////////////////////////////////////////////////////////////////////////
	// event status and interrupt

	logic [`PIEB_EVT_W-1:0] evt_pulse;
	logic [`PIEB_EVT_W-1:0] evt_status;
	logic [`PIEB_EVT_W-1:0] evt_mask;
	logic                   bad_access;

	// an access to an unmapped offset is recorded in its access cycle
	assign bad_access = access_phase & (pieb_decode(paddr) == PIEB_SEL_NONE);

	// bit 0 marks the rising edge of the raw request
	always_comb begin
		evt_pulse                       = `PIEB_EVT_RESET;
		evt_pulse[`PIEB_EVT_REQ_RISE]   = req_raw & ~periph_irq_req_reg;
		evt_pulse[`PIEB_EVT_BAD_ACCESS] = bad_access;
	end

	pieb_evt_irq u_evt_irq (
		.pclk       (pclk),
		.presetn    (presetn),
		.evt_pulse  (evt_pulse),
		.clr_en     (wr_evt_status),
		.mask_wr_en (wr_evt_mask),
		.wr_data    (pwdata[`PIEB_EVT_W-1:0]),
		.status     (evt_status),
		.mask       (evt_mask),
		.irq        (irq)
	);

	//////////////////////////////////////////////////////////////////////////////////////////////
	// read data and error, prepared in the setup cycle, and ready

	logic [7:0]  rbyte;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic        pready_reg;

	// byte of the register addressed in the setup cycle
	always_comb begin
		case (sel_setup)
			PIEB_SEL_CORE_CTRL:  rbyte = core_irq_control_reg;
			PIEB_SEL_EN1:        rbyte = periph_irq_enable_1_reg;
			PIEB_SEL_EN2:        rbyte = periph_irq_enable_2_reg;
			PIEB_SEL_EN3:        rbyte = periph_irq_enable_3_reg;
			PIEB_SEL_FLAGS1:     rbyte = periph_irq_flags_1;
			PIEB_SEL_FLAGS2:     rbyte = periph_irq_flags_2;
			PIEB_SEL_FLAGS3:     rbyte = periph_irq_flags_3;
			PIEB_SEL_EVT_STATUS: rbyte = {6'h00, evt_status};
			PIEB_SEL_EVT_MASK:   rbyte = {6'h00, evt_mask};
			default:             rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else if (setup_phase) begin
			pslverr_reg <= unmapped_setup;
		end
	end

	// no wait states: ready stands high from the first edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= 1'b1;
		end
	end

	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;
	assign pready  = pready_reg;

endmodule : pieb_top

// [sim/pieb_top_asserts.sv]
// concurrent checks on the ports of the peripheral interrupt bank
`timescale 1ns/10ps
`include "pieb_defines.svh"
module pieb_top_asserts
	import pieb_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// sources and core side
	input wire logic        serial_rx_level,
	input wire logic        serial_tx_level,
	input wire logic        periph_irq_req,
	input wire logic        global_irq_enable
);
	logic gate_reg;
	logic glob_reg;
	logic setup;
	logic mapped;
	assign setup = psel && !penable;
	assign mapped = paddr <= 8'h20 && paddr[1:0] == 2'h0;
	// mirror of the core control bits as written over the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gate_reg <= 1'b0;
			glob_reg <= 1'b0;
		end else if (psel && penable && pwrite && paddr == `PIEB_OFF_CORE_CTRL) begin
			gate_reg <= pwdata[`PIEB_BIT_PERIPH_GATE];
			glob_reg <= pwdata[`PIEB_BIT_GLOBAL_EN];
		end
	end
	////////////////////////////////
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_no_wait: assert property ($past(presetn) |-> pready)
		else $error("pready low outside reset");
	a_high_bits_zero: assert property (setup |=> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (setup && mapped |=> !pslverr)
		else $error("mapped access refused");
	a_top_bit_zero: assert property (setup && (paddr == 8'h0c || paddr == 8'h18) |=> !prdata[7])
		else $error("bank 3 bit 7 not zero");
	a_bit_four_zero: assert property (setup && (paddr == 8'h08 || paddr == 8'h14) |=> !prdata[4])
		else $error("bank 2 bit 4 not zero");
	a_serial_follow: assert property (setup && !pwrite && paddr == 8'h10 && $past(presetn) |=>
		prdata[5] == $past(serial_rx_level, 2) && prdata[4] == $past(serial_tx_level, 2))
		else $error("serial flags do not follow levels");
	a_gate_blocks: assert property (!$past(gate_reg) |-> !periph_irq_req)
		else $error("request without peripheral gate");
	a_global_copy: assert property (global_irq_enable == $past(glob_reg))
		else $error("global enable copy wrong");
	c_flags_read: cover property (setup && paddr == 8'h10);
	c_req_seen: cover property (periph_irq_req);
	c_refused: cover property (pslverr);
endmodule : pieb_top_asserts
bind pieb_top pieb_top_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.prdata, .pslverr, .serial_rx_level, .serial_tx_level, .periph_irq_req, .global_irq_enable);

// [sim/pieb_periph_model.sv]
// peripherals raising their conditions toward the interrupt bank
`timescale 1ns/10ps
module pieb_periph_model (
	// clock
	input wire logic  pclk,
	// conditions
	output logic [7:0] flag_set_1,
	output logic [7:0] flag_set_2,
	output logic [7:0] flag_set_3,
	output logic       serial_rx_level,
	output logic       serial_tx_level
);
	initial begin
		flag_set_1 = 8'h00;
		flag_set_2 = 8'h00;
		flag_set_3 = 8'h00;
		serial_rx_level = 1'b0;
		serial_tx_level = 1'b0;
	end
	// one-cycle condition pulses, raised whatever the enables say
	task automatic pulse(input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] s3);
		@(posedge pclk);
		flag_set_1 <= s1;
		flag_set_2 <= s2;
		flag_set_3 <= s3;
		@(posedge pclk);
		flag_set_1 <= 8'h00;
		flag_set_2 <= 8'h00;
		flag_set_3 <= 8'h00;
	endtask : pulse
	task automatic levels(input logic rx, input logic tx);
		@(posedge pclk);
		serial_rx_level <= rx;
		serial_tx_level <= tx;
	endtask : levels
endmodule : pieb_periph_model

// [sim/pieb_top_bench.sv]
// self-checking bench for the peripheral interrupt bank
`timescale 1ns/10ps
`include "pieb_defines.svh"
module pieb_top_bench
	import pieb_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic [7:0]  flag_set_1;
	logic [7:0]  flag_set_2;
	logic [7:0]  flag_set_3;
	logic        serial_rx_level;
	logic        serial_tx_level;
	logic        periph_irq_req;
	logic        global_irq_enable;
	logic        irq;
	logic [31:0] rd;
	logic        err;
	int          n_errors;
	int          samples_checked;
	logic [7:0]  offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
	logic [7:0]  rwm  [7] = '{8'hc0, 8'hff, 8'hef, 8'h7f, 8'hcf, 8'hef, 8'h7f};
	pieb_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.flag_set_1, .flag_set_2, .flag_set_3, .serial_rx_level, .serial_tx_level,
		.periph_irq_req, .global_irq_enable, .irq);
	pieb_periph_model per_u (.pclk, .flag_set_1, .flag_set_2, .flag_set_3, .serial_rx_level, .serial_tx_level);
	////////////////////////////////
	task automatic end_sim();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		int i;
		i = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (pready !== 1'b1) begin
			n_errors++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] addr, input logic [31:0] exp);
		apb(1'b0, addr, 32'h0);
		chk(rd, exp);
	endtask : rchk
	// 0 request, 1 global enable, 2 interrupt, looked at once settled
	task automatic ochk(input int sel, input logic e);
		logic [2:0] v;
		repeat (2) @(posedge pclk);
		#1;
		v = {irq, global_irq_enable, periph_irq_req};
		chk({31'h0, v[sel]}, {31'h0, e});
	endtask : ochk
	////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_errors = 0;
		samples_checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 7; k++) rchk(offs[k], 32'h0);
		for (int k = 0; k < 7; k++) begin
			apb(1'b1, offs[k], 32'hffff_ffff);
			rchk(offs[k], {24'h0, rwm[k]});
			apb(1'b1, offs[k], 32'h0);
		end
		// refused access raises the masked event interrupt
		apb(1'b0, 8'h24, 32'h0);
		chk({31'h0, err}, 32'h1);
		rchk(`PIEB_OFF_EVT_STATUS, 32'h2);
		ochk(2, 1'b0);
		apb(1'b1, `PIEB_OFF_EVT_MASK, 32'h2);
		ochk(2, 1'b1);
		apb(1'b1, `PIEB_OFF_EVT_STATUS, 32'h2);
		ochk(2, 1'b0);
		// conditions land with every enable and the gate off
		per_u.pulse(8'hff, 8'hff, 8'hff);
		rchk(`PIEB_OFF_FLAGS1, 32'hcf);
		rchk(`PIEB_OFF_FLAGS2, 32'hef);
		rchk(`PIEB_OFF_FLAGS3, 32'h7f);
		ochk(0, 1'b0);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, offs[4+k], 32'h0);
			apb(1'b1, offs[1+k], 32'h41);
			per_u.pulse(8'(k == 0), 8'(k == 1), 8'(k == 2));
			ochk(0, 1'b0);
			apb(1'b1, `PIEB_OFF_CORE_CTRL, 32'h40);
			ochk(0, 1'b1);
			apb(1'b1, offs[4+k], 32'h0);
			ochk(0, 1'b0);
			apb(1'b1, `PIEB_OFF_CORE_CTRL, 32'h0);
			apb(1'b1, offs[1+k], 32'h0);
		end
		apb(1'b1, `PIEB_OFF_CORE_CTRL, 32'h80);
		ochk(1, 1'b1);
		per_u.levels(1'b1, 1'b0);
		rchk(`PIEB_OFF_FLAGS1, 32'h20);
		apb(1'b1, `PIEB_OFF_FLAGS1, 32'h0);
		rchk(`PIEB_OFF_FLAGS1, 32'h20);
		per_u.levels(1'b0, 1'b1);
		rchk(`PIEB_OFF_FLAGS1, 32'h10);
		// a second reset in mid-run clears every bank again
		per_u.levels(1'b0, 1'b0);
		per_u.pulse(8'hff, 8'hff, 8'hff);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 7; k++) rchk(offs[k], 32'h0);
		rchk(`PIEB_OFF_EVT_STATUS, 32'h0);
		ochk(1, 1'b0);
		end_sim();
	end
endmodule : pieb_top_bench
